// File: common/bpt_pkg.sv
package bpt_pkg;

    // ----------------------------------------------------------------
    // Bus geometry
    // ----------------------------------------------------------------
    localparam int BPT_ADDR_W = 12;            // APB byte address width
    localparam int BPT_DATA_W = 32;            // APB data width

    // ----------------------------------------------------------------
    // Register indexes (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [7:0] BPT_IDX_A_HI_UP = 8'hA6;  // Channel A high time, bits 10..8
    localparam logic [7:0] BPT_IDX_A_HI_LO = 8'hA7;  // Channel A high time, bits 7..0
    localparam logic [7:0] BPT_IDX_A_LO_UP = 8'hA9;  // Channel A low time, bits 10..8
    localparam logic [7:0] BPT_IDX_A_LO_LO = 8'hAA;  // Channel A low time, bits 7..0
    localparam logic [7:0] BPT_IDX_B_HI_UP = 8'hAB;  // Channel B high time, bits 10..8
    localparam logic [7:0] BPT_IDX_B_HI_LO = 8'hAC;  // Channel B high time, bits 7..0
    localparam logic [7:0] BPT_IDX_B_LO_UP = 8'hAD;  // Channel B low time, bits 10..8
    localparam logic [7:0] BPT_IDX_B_LO_LO = 8'hAE;  // Channel B low time, bits 7..0
    localparam logic [7:0] BPT_IDX_PCNT_A  = 8'hAF;  // Channel A pulse total
    localparam logic [7:0] BPT_IDX_PCNT_B  = 8'hB1;  // Channel B pulse total
    localparam logic [7:0] BPT_IDX_DEAD    = 8'hB2;  // Deadtime
    localparam logic [7:0] BPT_IDX_CTRL    = 8'hB8;  // Start and stop strobes
    localparam logic [7:0] BPT_IDX_STAT    = 8'hB9;  // Busy and output levels

    // ----------------------------------------------------------------
    // Field layout and reset values
    // ----------------------------------------------------------------
    localparam int BPT_NCH      = 2;           // Channel A is index 0, B is 1
    localparam int BPT_DUR_W    = 11;          // Phase duration width
    localparam int BPT_UP_W     = 3;           // Duration bits held in upper byte
    localparam int BPT_PER_W    = 12;          // Whole pulse period width
    localparam int BPT_PCNT_W   = 6;           // Pulse total width, 0 to 63
    localparam int BPT_RUN_W    = 12;          // Width of the high and low run check counters
    localparam int BPT_CTRL_GO  = 0;           // Control bit that starts a burst
    localparam int BPT_CTRL_END = 1;           // Control bit that aborts a burst
    localparam logic [7:0] BPT_REG_RST = 8'h00;

    // ----------------------------------------------------------------
    // Channel sequencer states
    // ----------------------------------------------------------------
    typedef enum logic {
        BPT_CH_IDLE  = 1'b0,                   // Output rests low
        BPT_CH_BURST = 1'b1                    // Pulses are being emitted
    } bpt_ch_st_t;

endpackage : bpt_pkg

// File: common/bpt_chan_if.sv
`timescale 1ns/1ps
`default_nettype none

// Ties one channel's sequencer to its phase timer and pulse counter
interface bpt_chan_if;
    import bpt_pkg::*;

    logic                  clr;       // Restart the pulse at position zero
    logic                  run;       // Channel is inside a burst
    logic [BPT_PER_W-1:0]  period;    // High plus low phase length
    logic [BPT_DUR_W-1:0]  high_len;  // High phase after deadtime is shaved
    logic                  wrap;      // Last cycle of the current pulse
    logic                  level;     // Wanted output level this cycle
    logic                  load;      // Load the pulse total
    logic                  dec;       // One pulse has finished
    logic [BPT_PCNT_W-1:0] count;     // Pulse total to load
    logic                  last;      // Only one pulse remains

    modport tmr (input clr, run, period, high_len, output wrap, level);
    modport cnt (input load, dec, count, output last);
endinterface : bpt_chan_if

`default_nettype wire

// File: hdl/bpt_phase_timer.sv
`timescale 1ns/1ps
`default_nettype none

// Position counter within one pulse; one step per core clock
module bpt_phase_timer
    import bpt_pkg::*;
(
    // Clock and control
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    input  wire logic ce_i,
    // Channel link
    bpt_chan_if.tmr   ch
);

    typedef struct packed {
        logic [BPT_PER_W-1:0] pos;   // Cycle within the pulse
    } bpt_tmr_state_t;

    bpt_tmr_state_t st_r;
    bpt_tmr_state_t st_nxt;

    // Zero-length period wraps every cycle, so a pulse never lasts 0 cycles
    assign ch.wrap  = ch.run && ({1'b0, st_r.pos} + 13'h0001 >= {1'b0, ch.period});
    // High while inside the shaved high phase
    assign ch.level = ch.run && (st_r.pos < {1'b0, ch.high_len});

    // ----------------------------------------------------------------
    // Next position
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (!ch.run || ch.clr || ch.wrap) begin
            st_nxt.pos = '0;
        end else begin
            st_nxt.pos = st_r.pos + 12'h001;
        end
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            st_r <= '0;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

endmodule : bpt_phase_timer

`default_nettype wire

// File: hdl/bpt_pulse_counter.sv
`timescale 1ns/1ps
`default_nettype none

// Counts the pulses that remain in a burst
module bpt_pulse_counter
    import bpt_pkg::*;
(
    // Clock and control
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    input  wire logic ce_i,
    // Channel link
    bpt_chan_if.cnt   ch
);

    typedef struct packed {
        logic [BPT_PCNT_W-1:0] left;  // Pulses still to emit
    } bpt_cnt_state_t;

    bpt_cnt_state_t st_r;
    bpt_cnt_state_t st_nxt;

    assign ch.last = (st_r.left == 6'h01);

    // ----------------------------------------------------------------
    // Load beats decrement so a restart always takes the new total
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (ch.load) begin
            st_nxt.left = ch.count;
        end else if (ch.dec && st_r.left != 6'h00) begin
            st_nxt.left = st_r.left - 6'h01;
        end
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            st_r <= '0;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

endmodule : bpt_pulse_counter

`default_nettype wire

// File: hdl/bpt_burst_timing.sv
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Channel A output high for high time
// - Channel A output low for low time
// - Channel B output high for high time
// - Channel B output low for low time
// - One duration count is one clock
// - A high time: upper and lower byte
// - A low time: upper and lower byte
// - B high time: upper and lower byte
// - B low upper bits; bits 7-3 RW
// - Reset clears every duration register
// - B low time lower byte register
// - Burst emits the programmed pulse total
// - Deadtime shaved off each high phase
module bpt_burst_timing
    import bpt_pkg::*;
(
    // Clock, reset and freeze
    input  wire logic                  core_clk_i,
    input  wire logic                  reset_i,
    input  wire logic                  ce_i,
    // APB slave
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [BPT_ADDR_W-1:0] paddr_i,
    input  wire logic [BPT_DATA_W-1:0] pwdata_i,
    input  wire logic [3:0]            pstrb_i,
    output logic      [BPT_DATA_W-1:0] prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    // Low-side driver outputs
    output logic                       drive_output_first_o,
    output logic                       drive_output_second_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [BPT_NCH-1:0][7:0]  hi_up;   // High time upper bytes
        logic [BPT_NCH-1:0][7:0]  hi_lo;   // High time lower bytes
        logic [BPT_NCH-1:0][7:0]  lo_up;   // Low time upper bytes
        logic [BPT_NCH-1:0][7:0]  lo_lo;   // Low time lower bytes
        logic [BPT_NCH-1:0][7:0]  pcnt;    // Pulse totals
        logic [7:0]               dead;    // Deadtime in clocks
        bpt_ch_st_t [BPT_NCH-1:0] ch;      // Channel sequencers
        logic [BPT_NCH-1:0]       drv;     // Registered driver levels
        logic                     ready;   // APB answer cycle
        logic                     slverr;  // APB error answer
        logic [BPT_DATA_W-1:0]    rdata;   // APB read data
    } bpt_state_t;

    bpt_state_t st_r;
    bpt_state_t st_nxt;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Joins an upper and lower byte into one duration
    function automatic logic [BPT_DUR_W-1:0] dur(input logic [7:0] up, input logic [7:0] lo);
        return {up[BPT_UP_W-1:0], lo};
    endfunction : dur

    // High phase with the deadtime taken off its end, never below zero
    function automatic logic [BPT_DUR_W-1:0] shave(input logic [BPT_DUR_W-1:0] on,
                                                   input logic [7:0]           dt);
        return (on > {3'h0, dt}) ? on - {3'h0, dt} : '0;
    endfunction : shave

    // True for every index that answers without error
    function automatic logic mapped(input logic [7:0] idx);
        return idx inside {BPT_IDX_A_HI_UP, BPT_IDX_A_HI_LO, BPT_IDX_A_LO_UP, BPT_IDX_A_LO_LO,
                           BPT_IDX_B_HI_UP, BPT_IDX_B_HI_LO, BPT_IDX_B_LO_UP, BPT_IDX_B_LO_LO,
                           BPT_IDX_PCNT_A, BPT_IDX_PCNT_B, BPT_IDX_DEAD, BPT_IDX_CTRL,
                           BPT_IDX_STAT};
    endfunction : mapped

    // Read mux; unused upper bits read back as written
    function automatic logic [7:0] reg_rd(input bpt_state_t s, input logic [7:0] idx);
        case (idx)
            BPT_IDX_A_HI_UP: return s.hi_up[0];
            BPT_IDX_A_HI_LO: return s.hi_lo[0];
            BPT_IDX_A_LO_UP: return s.lo_up[0];
            BPT_IDX_A_LO_LO: return s.lo_lo[0];
            BPT_IDX_B_HI_UP: return s.hi_up[1];
            BPT_IDX_B_HI_LO: return s.hi_lo[1];
            BPT_IDX_B_LO_UP: return s.lo_up[1];
            BPT_IDX_B_LO_LO: return s.lo_lo[1];
            BPT_IDX_PCNT_A:  return s.pcnt[0];
            BPT_IDX_PCNT_B:  return s.pcnt[1];
            BPT_IDX_DEAD:    return s.dead;
            BPT_IDX_STAT:    return {4'h0, s.drv, s.ch[1] == BPT_CH_BURST, s.ch[0] == BPT_CH_BURST};
            default:         return 8'h00;
        endcase
    endfunction : reg_rd

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic [7:0] idx_w;   // Register index
    logic       acc_w;   // Access phase
    logic       ok_w;    // Aligned, in range and mapped
    logic       wr_w;    // Write taken this cycle
    logic       go_w;    // Start strobe
    logic       end_w;   // Abort strobe

    assign idx_w = paddr_i[9:2];
    assign acc_w = psel_i && penable_i;
    assign ok_w  = (paddr_i[1:0] == 2'h0) && (paddr_i[11:10] == 2'h0) && mapped(idx_w);
    // Data sits in byte lane 0, so only that strobe matters
    assign wr_w  = acc_w && !st_r.ready && pwrite_i && pstrb_i[0] && ok_w;
    assign go_w  = wr_w && (idx_w == BPT_IDX_CTRL) && pwdata_i[BPT_CTRL_GO];
    assign end_w = wr_w && (idx_w == BPT_IDX_CTRL) && pwdata_i[BPT_CTRL_END];

    // ----------------------------------------------------------------
    // Channel datapath
    // ----------------------------------------------------------------
    logic [BPT_DUR_W-1:0] hi_eff_w [BPT_NCH];  // Shaved high phase
    logic [BPT_PER_W-1:0] per_w    [BPT_NCH];  // Whole pulse length
    logic [BPT_NCH-1:0]   wrap_w;              // Pulse ends this cycle
    logic [BPT_NCH-1:0]   last_w;              // Final pulse in progress
    logic [BPT_NCH-1:0]   level_w;             // Timer's wanted level

    bpt_chan_if ch_if [BPT_NCH] ();

    for (genvar g = 0; g < BPT_NCH; g++) begin : g_ch
        assign hi_eff_w[g] = shave(dur(st_r.hi_up[g], st_r.hi_lo[g]), st_r.dead);
        // Full pulse keeps its length; deadtime only moves the falling edge
        assign per_w[g]    = {1'b0, dur(st_r.hi_up[g], st_r.hi_lo[g])}
                           + {1'b0, dur(st_r.lo_up[g], st_r.lo_lo[g])};
        assign ch_if[g].clr      = go_w;
        assign ch_if[g].run      = (st_r.ch[g] == BPT_CH_BURST);
        assign ch_if[g].period   = per_w[g];
        assign ch_if[g].high_len = hi_eff_w[g];
        assign ch_if[g].load     = go_w;
        assign ch_if[g].dec      = wrap_w[g];
        assign ch_if[g].count    = st_r.pcnt[g][BPT_PCNT_W-1:0];
        assign wrap_w[g]         = ch_if[g].wrap;
        assign last_w[g]         = ch_if[g].last;
        assign level_w[g]        = ch_if[g].level;

        // Position within the pulse
        bpt_phase_timer u_timer (
            .core_clk_i (core_clk_i),
            .reset_i    (reset_i),
            .ce_i       (ce_i),
            .ch         (ch_if[g])
        );

        // Pulses left in the burst
        bpt_pulse_counter u_count (
            .core_clk_i (core_clk_i),
            .reset_i    (reset_i),
            .ce_i       (ce_i),
            .ch         (ch_if[g])
        );
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // One wait state: answer comes the cycle after the access begins
        if (acc_w && !st_r.ready) begin
            st_nxt.ready  = 1'b1;
            st_nxt.slverr = !ok_w;
            st_nxt.rdata  = '0;
            if (ok_w && !pwrite_i) begin
                st_nxt.rdata = {24'h000000, reg_rd(st_r, idx_w)};
            end
        end else begin
            st_nxt.ready  = 1'b0;
            st_nxt.slverr = 1'b0;
        end
        // Register writes; all eight bits kept, even the unused ones
        if (wr_w) begin
            case (idx_w)
                BPT_IDX_A_HI_UP: st_nxt.hi_up[0] = pwdata_i[7:0];
                BPT_IDX_A_HI_LO: st_nxt.hi_lo[0] = pwdata_i[7:0];
                BPT_IDX_A_LO_UP: st_nxt.lo_up[0] = pwdata_i[7:0];
                BPT_IDX_A_LO_LO: st_nxt.lo_lo[0] = pwdata_i[7:0];
                BPT_IDX_B_HI_UP: st_nxt.hi_up[1] = pwdata_i[7:0];
                BPT_IDX_B_HI_LO: st_nxt.hi_lo[1] = pwdata_i[7:0];
                BPT_IDX_B_LO_UP: st_nxt.lo_up[1] = pwdata_i[7:0];
                BPT_IDX_B_LO_LO: st_nxt.lo_lo[1] = pwdata_i[7:0];
                BPT_IDX_PCNT_A:  st_nxt.pcnt[0]  = pwdata_i[7:0];
                BPT_IDX_PCNT_B:  st_nxt.pcnt[1]  = pwdata_i[7:0];
                BPT_IDX_DEAD:    st_nxt.dead     = pwdata_i[7:0];
                // Control holds no state; status is read only
                default: ;
            endcase
        end
        // Channel sequencers; a start also restarts a running burst
        for (int c = 0; c < BPT_NCH; c++) begin
            if (go_w) begin
                st_nxt.ch[c] = (st_r.pcnt[c][BPT_PCNT_W-1:0] != 6'h00) ? BPT_CH_BURST : BPT_CH_IDLE;
            end else if (end_w) begin
                st_nxt.ch[c] = BPT_CH_IDLE;
            end else if (st_r.ch[c] == BPT_CH_BURST && wrap_w[c] && last_w[c]) begin
                st_nxt.ch[c] = BPT_CH_IDLE;
            end
            // Output follows the timer one clock later on both channels
            st_nxt.drv[c] = level_w[c];
        end
    end

    // State register; reset clears every setting to zero
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            st_r <= '0;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata_o              = st_r.rdata;
    assign pready_o              = st_r.ready;
    assign pslverr_o             = st_r.slverr;
    assign drive_output_first_o  = st_r.drv[0];
    assign drive_output_second_o = st_r.drv[1];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [BPT_RUN_W-1:0] hi_run [BPT_NCH];  // Cycles the output has been high
    logic [BPT_RUN_W-1:0] lo_run [BPT_NCH];  // Cycles the output has been low
    logic [BPT_NCH-1:0]   seen;              // A fall happened in this burst
    logic [6:0]           rises  [BPT_NCH];  // Rising edges since start

    // Check counters; they freeze with the rest of the block
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            hi_run <= '{default: '0};
            lo_run <= '{default: '0};
            rises  <= '{default: '0};
            seen   <= '0;
        end else if (ce_i) begin
            for (int c = 0; c < BPT_NCH; c++) begin
                hi_run[c] <= st_r.drv[c] ? hi_run[c] + 12'h001 : 12'h000;
                lo_run[c] <= st_r.drv[c] ? 12'h000 : lo_run[c] + 12'h001;
                if (st_r.ch[c] == BPT_CH_IDLE) begin
                    seen[c] <= 1'b0;
                end else if (st_r.drv[c] && !st_nxt.drv[c]) begin
                    seen[c] <= 1'b1;
                end
                if (go_w) begin
                    rises[c] <= 7'h00;
                end else if (st_nxt.drv[c] && !st_r.drv[c]) begin
                    rises[c] <= rises[c] + 7'h01;
                end
            end
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    // Start of a channel A burst and its first level
    sequence a_go_s;
        go_w && ce_i && st_r.pcnt[0][BPT_PCNT_W-1:0] != 6'h00;
    endsequence
    sequence a_first_s;
        st_r.ch[0] == BPT_CH_BURST ##1 st_r.drv[0] == (hi_eff_w[0] != 11'h000);
    endsequence

    a_high_time_a: assert property (
        $fell(st_r.drv[0]) && st_r.ch[0] == BPT_CH_BURST && {1'b0, hi_eff_w[0]} < per_w[0]
        |-> hi_run[0] == {1'b0, hi_eff_w[0]})
        else $error("channel A high phase length wrong");
    a_low_time_a: assert property (
        $rose(st_r.drv[0]) && seen[0] && st_r.ch[0] == BPT_CH_BURST
        |-> lo_run[0] == per_w[0] - {1'b0, hi_eff_w[0]})
        else $error("channel A low phase length wrong");
    b_high_time_a: assert property (
        $fell(st_r.drv[1]) && st_r.ch[1] == BPT_CH_BURST && {1'b0, hi_eff_w[1]} < per_w[1]
        |-> hi_run[1] == {1'b0, hi_eff_w[1]})
        else $error("channel B high phase length wrong");
    b_low_time_a: assert property (
        $rose(st_r.drv[1]) && seen[1] && st_r.ch[1] == BPT_CH_BURST
        |-> lo_run[1] == per_w[1] - {1'b0, hi_eff_w[1]})
        else $error("channel B low phase length wrong");
    a_hi_write_a: assert property (
        wr_w && ce_i && idx_w == BPT_IDX_A_HI_UP |=> st_r.hi_up[0] == $past(pwdata_i[7:0]))
        else $error("channel A high upper byte not stored");
    b_lo_write_a: assert property (
        wr_w && ce_i && idx_w == BPT_IDX_B_LO_LO |=> st_r.lo_lo[1] == $past(pwdata_i[7:0]))
        else $error("channel B low lower byte not stored");
    reset_zero_a: assert property (disable iff (1'b0)
        reset_i |=> st_r.hi_up == '0 && st_r.hi_lo == '0 && st_r.lo_up == '0 && st_r.lo_lo == '0)
        else $error("duration registers not cleared by reset");
    burst_start_a: assert property (disable iff (reset_i || !ce_i)
        a_go_s |=> a_first_s)
        else $error("channel A burst did not start");
    pulse_total_a: assert property (
        $past(st_r.ch[0]) == BPT_CH_BURST && st_r.ch[0] == BPT_CH_IDLE && !$past(wr_w)
        && hi_eff_w[0] != 11'h000 && {1'b0, hi_eff_w[0]} < per_w[0]
        |-> rises[0] == {1'b0, st_r.pcnt[0][BPT_PCNT_W-1:0]})
        else $error("channel A pulse total wrong");
    rest_low_a: assert property (
        $past(st_r.ch[1]) == BPT_CH_IDLE && st_r.ch[1] == BPT_CH_IDLE |-> !st_r.drv[1])
        else $error("channel B output not resting low");

    // Deadtime: a low run inside a burst is never shorter
    a_dead_gap_a: assert property (
        $rose(st_r.drv[0]) && seen[0] |-> lo_run[0] >= {4'h0, st_r.dead})
        else $error("channel A deadtime gap short");

    b_dead_gap_a: assert property (
        $rose(st_r.drv[1]) && seen[1] |-> lo_run[1] >= {4'h0, st_r.dead})
        else $error("channel B deadtime gap short");

    // Channel A rests low as well once idle
    a_rest_low_a: assert property (
        $past(st_r.ch[0]) == BPT_CH_IDLE && st_r.ch[0] == BPT_CH_IDLE |-> !st_r.drv[0])
        else $error("channel A output not resting low");

    // Low time upper byte of channel A lands as written
    a_lo_write_a: assert property (
        wr_w && ce_i && idx_w == BPT_IDX_A_LO_UP |=> st_r.lo_up[0] == $past(pwdata_i[7:0]))
        else $error("channel A low upper byte not stored");

    // Answer follows one cycle after the access is taken;
    // a low clock enable only delays it
    bus_answer_a: assert property (
        acc_w && !st_r.ready && ce_i |=> st_r.ready)
        else $error("bus access not answered");

endmodule : bpt_burst_timing

`default_nettype wire

// File: tb/bpt_xducer_model.sv
`timescale 1ns/1ps
`default_nettype none

// Transducer load: measures the last high and low run and counts rising edges
module bpt_xducer_model (
    // Clock and reset
    input  wire logic            core_clk_i,
    input  wire logic            reset_i,
    input  wire logic            clr_i,
    // Low-side driver levels, channel A is bit 0
    input  wire logic [1:0]      drive_i,
    // Measured figures, one step per clock
    output logic [1:0][11:0]     hi_len_o,
    output logic [1:0][11:0]     lo_len_o,
    output logic [1:0][7:0]      rises_o
);
    logic [1:0][11:0] run_r;     // Length of the current run
    logic [1:0]       lvl_r;     // Level in the previous cycle

    // A run is only known when it ends, so the last low is taken at a rise
    always_ff @(posedge core_clk_i) begin
        for (int c = 0; c < 2; c++) begin
            if (reset_i) begin
                {hi_len_o[c], lo_len_o[c], rises_o[c], run_r[c], lvl_r[c]} <= '0;
            end else begin
                if (drive_i[c] != lvl_r[c]) begin
                    if (lvl_r[c]) hi_len_o[c] <= run_r[c];
                    else lo_len_o[c] <= run_r[c];
                    run_r[c] <= 12'h001;
                end else begin
                    run_r[c] <= run_r[c] + 12'h001;
                end
                if (clr_i) rises_o[c] <= 8'h00;
                else if (drive_i[c] && !lvl_r[c]) rises_o[c] <= rises_o[c] + 8'h01;
                lvl_r[c] <= drive_i[c];
            end
        end
    end
endmodule : bpt_xducer_model

`default_nettype wire

// File: tb/tb_burst_pulse_timing.sv
`timescale 1ns/1ps
`default_nettype none

module tb_burst_pulse_timing;
    import bpt_pkg::*;
    logic                  core_clk_i = 1'b0;
    logic                  reset_i    = 1'b1;
    logic                  psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clr = 1'b0, err;
    logic [BPT_ADDR_W-1:0] paddr      = '0;
    logic [BPT_DATA_W-1:0] pwdata     = '0;
    logic [BPT_DATA_W-1:0] prdata;
    logic                  pready, pslverr;
    logic [1:0]            drv;
    logic [1:0][11:0]      hi_len, lo_len;
    logic [1:0][7:0]       rises;
    logic [7:0]            rd;
    int                    n_errors = 0;
    int                    samples_checked = 0;
    // Duration registers and the settings of the first burst
    logic [7:0] regs [8] = '{8'hA6, 8'hA7, 8'hA9, 8'hAA, 8'hAB, 8'hAC, 8'hAD, 8'hAE};
    logic [7:0] vals [8] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h03, 8'h01, 8'h07};

    always #25 core_clk_i = ~core_clk_i;

    bpt_burst_timing dut_u (.core_clk_i(core_clk_i), .reset_i(reset_i), .ce_i(1'b1), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .drive_output_first_o(drv[0]), .drive_output_second_o(drv[1]));

    bpt_xducer_model xd_u (.core_clk_i(core_clk_i), .reset_i(reset_i), .clr_i(clr), .drive_i(drv),
        .hi_len_o(hi_len), .lo_len_o(lo_len), .rises_o(rises));

    // ----------------------------------------------------------------
    // Bus and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Request held until pready is seen high; the watchdog ends a hang
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge core_clk_i);
        {psel, penable, pwrite} <= {1'b1, 1'b0, wr};
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge core_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge core_clk_i);
        end while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb

    task automatic rdchk(input logic [7:0] idx, input logic [8:0] exp);
        apb(1'b0, idx, 8'h00);
        chk({23'h0, err, rd}, {23'h0, exp});
    endtask : rdchk

    // Start both channels, then poll status until both are idle
    task automatic burst(input logic [7:0] dead);
        apb(1'b1, 8'hB2, dead);
        clr <= 1'b1;
        apb(1'b1, 8'hB8, 8'h01);
        clr <= 1'b0;
        for (int i = 0; i < 400; i++) begin
            apb(1'b0, 8'hB9, 8'h00);
            if (rd[1:0] == 2'b00) break;
        end
        chk({28'h0, rd[3:0]}, 32'h0000_0000);
    endtask : burst

    task automatic meas(input logic [11:0] ha, la, hb, lb);
        chk(32'(hi_len[0]), 32'(ha));
        chk(32'(lo_len[0]), 32'(la));
        chk(32'(hi_len[1]), 32'(hb));
        chk(32'(lo_len[1]), 32'(lb));
        chk(32'(rises), 32'h0000_0203);
    endtask : meas

    task automatic results;
        $display("Checked %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge core_clk_i);
        reset_i <= 1'b0;
        foreach (regs[i]) rdchk(regs[i], 9'h000);
        foreach (regs[i]) begin
            apb(1'b1, regs[i], ~regs[i]);
            rdchk(regs[i], {1'b0, ~regs[i]});
        end
        rdchk(8'hA8, 9'h100);
        $display("Register tests done");
        foreach (regs[i]) apb(1'b1, regs[i], vals[i]);
        apb(1'b1, 8'hAF, 8'h03);
        apb(1'b1, 8'hB1, 8'h02);
        burst(8'h00);
        meas(12'h101, 12'h101, 12'h003, 12'h107);
        $display("Plain burst done");
        burst(8'h02);
        meas(12'h0FF, 12'h103, 12'h001, 12'h109);
        $display("Deadtime burst done");
        apb(1'b1, 8'hAF, 8'h00);
        apb(1'b1, 8'hB8, 8'h01);
        rdchk(8'hB9, 9'h002);
        apb(1'b1, 8'hB8, 8'h02);
        rdchk(8'hB9, 9'h000);
        $display("Abort test done");
        results();
    end

    // Bursts take about 3,100 cycles; this leaves ample margin
    initial begin
        repeat (20000) @(posedge core_clk_i);
        n_errors++;
        results();
    end
endmodule : tb_burst_pulse_timing

`default_nettype wire
